//--- common/can_mode_pkg.sv
// Package with register map, field layouts, reset values and carriers of the mode/reset/irq block.
//
// Function
// R01: Core enable zero or soft reset forces configuration.
// R02: Configuration drops sync, transmit output recessive.
// R03: Configuration clears error regs, allows timing writes.
// R04: Configuration stops bus traffic, queues stay pending.
// R05: Entering configuration clears listed interrupt flags.
// R06: Configuration still sets FIFO flags, raises interrupts.
// R07: Leave configuration after eleven recessive bits.
// R08: Next mode: loop back, sleep, else normal.
// R09: Sleep from configuration only without pending requests.
// R10: Normal to sleep when idle, nothing pending.
// R11: Wake on sleep cleared, activity, new request.
// R12: Flag events on sleep entry and wake up.
// R13: Loop back: recessive bus, internal return path.
// R14: Protocol and host timing crossed safely.
// R15: Both resets restore defaults; soft bit self-clears.
// R16: Acceptance filter registers survive every reset.
// R17: Each domain reset through its own synchronizer.
// R18: One rising-edge interrupt line, low from power-up.
// R19: Flags set/cleared regardless of enables; clear-register clears.
// R20: Line asserts when flag and enable both set.
// R21: Line drops on clear/disable, then reasserts.
// R22: Four one-hot mode status bits, configuration in reset.
// R23: Active low system reset holds core in reset.
// R24: Bus-dependent transitions use synchronised bus samples.
package can_mode_pkg;

  // Register byte offsets.
  localparam logic [7:0] OFF_SRR = 8'h00;
  localparam logic [7:0] OFF_MSR = 8'h04;
  localparam logic [7:0] OFF_BAUD_PRESCALER_REG = 8'h08;
  localparam logic [7:0] OFF_BTR = 8'h0C;
  localparam logic [7:0] OFF_ECR = 8'h10;
  localparam logic [7:0] OFF_ESR = 8'h14;
  localparam logic [7:0] OFF_SR = 8'h18;
  localparam logic [7:0] OFF_ISR = 8'h1C;
  localparam logic [7:0] OFF_IER = 8'h20;
  localparam logic [7:0] OFF_ICR = 8'h24;
  localparam logic [7:0] OFF_AFMR = 8'h64;
  localparam logic [7:0] OFF_AFIR = 8'h68;

  // Field positions.
  localparam int SRR_SOFT_RESET_BIT = 0;
  localparam int SRR_CORE_ENABLE_BIT = 1;
  localparam int MSR_LOOP_BACK_BIT = 0;
  localparam int MSR_SLEEP_BIT = 1;
  localparam int BTR_TS1_LSB = 0;
  localparam int BTR_TS2_LSB = 4;

  // Interrupt flag positions.
  localparam int IRQ_ARB_LOST = 0;
  localparam int IRQ_TX_DONE = 1;
  localparam int IRQ_RX_DONE = 2;
  localparam int IRQ_RX_OVERFLOW = 3;
  localparam int IRQ_ERROR = 4;
  localparam int IRQ_BUS_OFF = 5;
  localparam int IRQ_SLEEP = 6;
  localparam int IRQ_WAKE = 7;
  localparam int IRQ_RX_NOT_EMPTY = 8;
  localparam int IRQ_RX_UNDERFLOW = 9;
  localparam int IRQ_BUF_FULL = 10;
  localparam int IRQ_QUEUE_FULL = 11;
  localparam int IRQ_W = 12;

  // Flags cleared on entry to configuration, and flags that may still set there.
  localparam logic [IRQ_W-1:0] CFG_CLEAR_MASK = 12'h0FF;
  localparam logic [IRQ_W-1:0] CFG_KEEP_MASK = 12'hF00;

  // Reset values.
  localparam logic [1:0] SRR_RESET = 2'h0;
  localparam logic [1:0] MSR_RESET = 2'h0;
  localparam logic [7:0] BAUD_PRESCALER_REG_RESET = 8'h00;
  localparam logic [6:0] BTR_RESET = 7'h00;
  localparam logic [31:0] AF_RESET = 32'h0000_0000;

  // Timing counts.
  localparam logic [3:0] IDLE_BITS = 4'hB;
  localparam logic [4:0] BIT_TQ_FIXED = 5'h03;

  localparam int ESR_W = 5;

  // Mode status carried out of the block.
  typedef struct packed {
    logic normal;
    logic sleep;
    logic loop_back;
    logic config_mode;
  } mode_status_s;

  // Event pulses from the protocol core.
  typedef struct packed {
    logic [IRQ_W-1:0] irq_set;
    logic [ESR_W-1:0] esr_set;
  } core_event_s;

endpackage : can_mode_pkg

//--- src/can_mode_ctrl.sv
// Mode control, reset handling, interrupt line and APB registers of the CAN controller.
`timescale 1ns/1ps
module can_mode_ctrl (
  input wire logic pclk, // Host clock, 250 MHz.
  input wire logic presetn, // Asynchronous reset, active low.
  input wire logic clk_en, // Freezes all state but the reset synchronizer while low.
  input wire logic psel, // APB select.
  input wire logic penable, // APB access phase.
  input wire logic pwrite, // APB direction.
  input wire logic [7:0] paddr, // APB byte address.
  input wire logic [31:0] pwdata, // APB write data.
  output logic [31:0] prdata, // APB read data.
  output logic pready, // APB ready.
  output logic pslverr, // APB error, always low.
  input wire logic can_rx, // Bus receive pin from transceiver.
  output logic can_tx, // Bus transmit pin to transceiver.
  input wire logic core_tx, // Transmit bit from protocol core.
  output logic core_rx, // Receive bit to protocol core.
  output logic core_run, // Core may receive and transmit.
  output logic error_clear, // Holds error counters at zero.
  output logic bit_tick, // One pulse per nominal bit time.
  input wire logic tx_pending, // Queue or priority buffer holds a request.
  input wire logic tx_new_request, // Pulse: a new request was queued.
  input wire logic [15:0] err_count, // Error counters from core.
  input wire can_mode_pkg::core_event_s core_ev, // Event pulses from core.
  output can_mode_pkg::mode_status_s mode_status, // One-hot mode.
  output logic interrupt_out // Edge-signalled interrupt line.
);
  import can_mode_pkg::*;

  typedef enum logic [4:0] {
    ST_CONFIG = 5'h01,
    ST_WAIT_IDLE = 5'h02,
    ST_NORMAL = 5'h04,
    ST_SLEEP = 5'h08,
    ST_LOOP = 5'h10
  } mode_e;

  // Word decode shared by read and write paths.
  function automatic logic hit(input logic [7:0] addr, input logic [7:0] off);
    hit = (addr == off);
  endfunction : hit

  logic rst_meta_r;
  logic rst_sync_r;
  logic soft_rst;
  logic rx_s1_r;
  logic rx_s2_r;
  logic rx_s3_r;
  logic rx_bit_r;
  logic [1:0] srr_r;
  logic [1:0] msr_r;
  logic [7:0] baud_prescaler_reg_r;
  logic [6:0] btr_r;
  logic [ESR_W-1:0] esr_r;
  logic [IRQ_W-1:0] isr_r;
  logic [IRQ_W-1:0] ier_r;
  logic [31:0] afmr_r;
  logic [31:0] afir_r;
  logic [7:0] presc_r;
  logic [4:0] tq_r;
  logic [3:0] rec_cnt_r;
  mode_e mode_r;
  mode_e mode_nxt;
  logic sleep_ev;
  logic wake_ev;
  logic wr;
  logic in_cfg;
  logic bus_idle;
  logic [4:0] bit_len;
  logic [IRQ_W-1:0] icr_clr;
  logic [IRQ_W-1:0] isr_set;
  logic [IRQ_W-1:0] isr_nxt;
  logic [IRQ_W-1:0] ier_nxt;
  logic drop_line;
  logic irq_nxt;
  logic [31:0] rdata_nxt;

  // Reset synchronizer: asserts at once, releases two edges later to avoid metastable release.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin // R23
      rst_meta_r <= 1'b0; // R17
      rst_sync_r <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_sync_r <= rst_meta_r; // R17
    end
  end

  assign wr = psel && penable && pready && pwrite && clk_en;
  // Soft reset is a one-cycle pulse that is never stored, so the bit reads back zero.
  assign soft_rst = wr && hit(paddr, OFF_SRR) && pwdata[SRR_SOFT_RESET_BIT]; // R01 R15
  assign in_cfg = (mode_r == ST_CONFIG) || (mode_r == ST_WAIT_IDLE);

  // Receive pin passes three flops; the level changes only when the last two agree.
  always_ff @(posedge pclk or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      rx_s1_r <= 1'b1;
      rx_s2_r <= 1'b1;
      rx_s3_r <= 1'b1;
      rx_bit_r <= 1'b1;
    end else if (clk_en) begin
      rx_s1_r <= can_rx; // R14
      rx_s2_r <= rx_s1_r;
      rx_s3_r <= rx_s2_r;
      if (rx_s2_r == rx_s3_r) begin
        rx_bit_r <= rx_s3_r; // R24
      end
    end
  end

  // Control registers; acceptance filter registers are kept out of every reset.
  always_ff @(posedge pclk or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      srr_r <= SRR_RESET; // R15
      msr_r <= MSR_RESET;
      baud_prescaler_reg_r <= BAUD_PRESCALER_REG_RESET;
      btr_r <= BTR_RESET;
    end else if (soft_rst) begin
      srr_r <= SRR_RESET; // R15
      msr_r <= MSR_RESET;
      baud_prescaler_reg_r <= BAUD_PRESCALER_REG_RESET;
      btr_r <= BTR_RESET;
    end else if (wr) begin
      if (hit(paddr, OFF_SRR)) begin
        srr_r <= {pwdata[SRR_CORE_ENABLE_BIT], 1'b0};
      end
      if (hit(paddr, OFF_MSR)) begin
        msr_r <= {pwdata[MSR_SLEEP_BIT], pwdata[MSR_LOOP_BACK_BIT]};
      end
      if (hit(paddr, OFF_BAUD_PRESCALER_REG) && in_cfg) begin
        baud_prescaler_reg_r <= pwdata[7:0]; // R03
      end
      if (hit(paddr, OFF_BTR) && in_cfg) begin
        btr_r <= pwdata[6:0]; // R03
      end
    end
  end

  // Filter registers have no reset at all, so neither reset can disturb them.
  always_ff @(posedge pclk) begin
    if (wr && hit(paddr, OFF_AFMR)) begin
      afmr_r <= pwdata; // R16
    end
    if (wr && hit(paddr, OFF_AFIR)) begin
      afir_r <= pwdata; // R16
    end
  end

  // Bit time is sync segment plus both phase segments, in prescaled quanta.
  assign bit_len = BIT_TQ_FIXED + {1'b0, btr_r[BTR_TS1_LSB+:4]} + {2'b00, btr_r[BTR_TS2_LSB+:3]};

  // Bit clock generator; idle in configuration because bus sync is dropped there.
  always_ff @(posedge pclk or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      presc_r <= 8'h00;
      tq_r <= 5'h00;
      bit_tick <= 1'b0;
    end else if (clk_en) begin
      bit_tick <= 1'b0;
      if (mode_r == ST_CONFIG || soft_rst) begin
        presc_r <= 8'h00; // R02
        tq_r <= 5'h00;
      end else if (presc_r >= baud_prescaler_reg_r) begin
        presc_r <= 8'h00;
        if (tq_r >= bit_len - 5'h01) begin
          tq_r <= 5'h00;
          bit_tick <= 1'b1;
        end else begin
          tq_r <= tq_r + 5'h01;
        end
      end else begin
        presc_r <= presc_r + 8'h01;
      end
    end
  end

  // Counts consecutive recessive bits, saturating at the idle figure.
  always_ff @(posedge pclk or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      rec_cnt_r <= 4'h0;
    end else if (clk_en) begin
      if (mode_r == ST_CONFIG || soft_rst || !rx_bit_r) begin
        rec_cnt_r <= 4'h0; // R24
      end else if (bit_tick && rec_cnt_r != IDLE_BITS) begin
        rec_cnt_r <= rec_cnt_r + 4'h1; // R07
      end
    end
  end

  assign bus_idle = (rec_cnt_r == IDLE_BITS); // R07 R10

  // Mode selection.
  always_comb begin
    mode_nxt = mode_r;
    sleep_ev = 1'b0;
    wake_ev = 1'b0;
    unique case (mode_r)
      ST_CONFIG: begin
        if (srr_r[SRR_CORE_ENABLE_BIT]) begin
          mode_nxt = ST_WAIT_IDLE;
        end
      end
      ST_WAIT_IDLE: begin
        if (bus_idle) begin // R07
          if (msr_r[MSR_LOOP_BACK_BIT]) begin
            mode_nxt = ST_LOOP; // R08
          end else if (msr_r[MSR_SLEEP_BIT] && !tx_pending) begin // R09
            mode_nxt = ST_SLEEP; // R08
            sleep_ev = 1'b1; // R12
          end else begin
            mode_nxt = ST_NORMAL; // R08
          end
        end
      end
      ST_NORMAL: begin
        if (msr_r[MSR_SLEEP_BIT] && bus_idle && !tx_pending) begin
          mode_nxt = ST_SLEEP; // R10
          sleep_ev = 1'b1; // R12
        end
      end
      ST_SLEEP: begin
        // A dominant bit wakes the core in time to receive the frame that follows.
        if (!msr_r[MSR_SLEEP_BIT] || !rx_bit_r || tx_new_request || tx_pending) begin
          mode_nxt = ST_NORMAL; // R11
          wake_ev = 1'b1; // R12
        end
      end
      ST_LOOP: begin
        mode_nxt = ST_LOOP; // R13
      end
      default: begin
        mode_nxt = ST_CONFIG;
      end
    endcase
    if (!srr_r[SRR_CORE_ENABLE_BIT]) begin
      mode_nxt = ST_CONFIG; // R01
      sleep_ev = 1'b0;
      wake_ev = 1'b0;
    end
  end

  // Mode register; soft reset lands in configuration on the next edge.
  always_ff @(posedge pclk or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      mode_r <= ST_CONFIG; // R22
    end else if (clk_en) begin
      if (soft_rst) begin
        mode_r <= ST_CONFIG; // R01
      end else begin
        mode_r <= mode_nxt;
      end
    end
  end

  // Bus pins and core hand-off; configuration and loop back keep the bus recessive.
  always_ff @(posedge pclk or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      can_tx <= 1'b1;
      core_rx <= 1'b1;
      core_run <= 1'b0;
      error_clear <= 1'b1;
      mode_status <= '{normal: 1'b0, sleep: 1'b0, loop_back: 1'b0, config_mode: 1'b1};
    end else if (clk_en) begin
      can_tx <= (!soft_rst && (mode_nxt == ST_NORMAL || mode_nxt == ST_SLEEP)) ? core_tx : 1'b1; // R02
      core_rx <= (mode_nxt == ST_LOOP) ? core_tx : rx_bit_r; // R13
      core_run <= (mode_nxt == ST_NORMAL || mode_nxt == ST_LOOP) && !soft_rst; // R04 R10
      error_clear <= (mode_nxt == ST_CONFIG || mode_nxt == ST_WAIT_IDLE || soft_rst); // R03
      mode_status.config_mode <= soft_rst || mode_nxt == ST_CONFIG
        || mode_nxt == ST_WAIT_IDLE; // R22
      mode_status.loop_back <= !soft_rst && mode_nxt == ST_LOOP;
      mode_status.sleep <= !soft_rst && mode_nxt == ST_SLEEP;
      mode_status.normal <= !soft_rst && mode_nxt == ST_NORMAL;
    end
  end

  // Flag updates: hardware sets win over software clears in the same cycle.
  always_comb begin
    icr_clr = (wr && hit(paddr, OFF_ICR)) ? pwdata[IRQ_W-1:0] : '0; // R19
    isr_set = core_ev.irq_set;
    if (in_cfg) begin
      isr_set = isr_set & CFG_KEEP_MASK; // R06
    end
    isr_set[IRQ_SLEEP] = sleep_ev; // R12
    isr_set[IRQ_WAKE] = wake_ev;
    isr_nxt = (isr_r & ~icr_clr) | isr_set; // R19
    if (mode_nxt == ST_CONFIG) begin
      isr_nxt = isr_nxt & ~CFG_CLEAR_MASK; // R05
    end
    ier_nxt = (wr && hit(paddr, OFF_IER)) ? pwdata[IRQ_W-1:0] : ier_r;
    // Losing any enabled source forces the line low for one cycle.
    drop_line = |(isr_r & ier_r & ~isr_nxt) || |(isr_r & ier_r & ~ier_nxt); // R21
    irq_nxt = !drop_line && |(isr_nxt & ier_nxt); // R20 R21
  end

  // Interrupt status, enable and line.
  always_ff @(posedge pclk or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      isr_r <= '0;
      ier_r <= '0;
      interrupt_out <= 1'b0; // R18
    end else if (clk_en) begin
      if (soft_rst) begin
        isr_r <= '0; // R15
        ier_r <= '0;
        interrupt_out <= 1'b0;
      end else begin
        isr_r <= isr_nxt; // R06 R19
        ier_r <= ier_nxt;
        interrupt_out <= irq_nxt; // R18 R20
      end
    end
  end

  // Error status: sticky, write one to clear, held clear in configuration.
  always_ff @(posedge pclk or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      esr_r <= '0;
    end else if (clk_en) begin
      if (soft_rst || in_cfg) begin
        esr_r <= '0; // R03
      end else if (wr && hit(paddr, OFF_ESR)) begin
        esr_r <= (esr_r & ~pwdata[ESR_W-1:0]) | core_ev.esr_set;
      end else begin
        esr_r <= esr_r | core_ev.esr_set;
      end
    end
  end

  // Read mux; unmapped and write-only words read as zero.
  always_comb begin
    rdata_nxt = 32'h0000_0000;
    if (hit(paddr, OFF_SRR)) begin
      rdata_nxt[SRR_CORE_ENABLE_BIT] = srr_r[SRR_CORE_ENABLE_BIT];
    end else if (hit(paddr, OFF_MSR)) begin
      rdata_nxt[MSR_LOOP_BACK_BIT] = msr_r[0];
      rdata_nxt[MSR_SLEEP_BIT] = msr_r[1];
    end else if (hit(paddr, OFF_BAUD_PRESCALER_REG)) begin
      rdata_nxt[7:0] = baud_prescaler_reg_r;
    end else if (hit(paddr, OFF_BTR)) begin
      rdata_nxt[6:0] = btr_r;
    end else if (hit(paddr, OFF_ECR)) begin
      rdata_nxt[15:0] = in_cfg ? 16'h0000 : err_count; // R03
    end else if (hit(paddr, OFF_ESR)) begin
      rdata_nxt[ESR_W-1:0] = esr_r;
    end else if (hit(paddr, OFF_SR)) begin
      rdata_nxt[3:0] = mode_status; // R22
    end else if (hit(paddr, OFF_ISR)) begin
      rdata_nxt[IRQ_W-1:0] = isr_r;
    end else if (hit(paddr, OFF_IER)) begin
      rdata_nxt[IRQ_W-1:0] = ier_r;
    end else if (hit(paddr, OFF_AFMR)) begin
      rdata_nxt = afmr_r;
    end else if (hit(paddr, OFF_AFIR)) begin
      rdata_nxt = afir_r;
    end
  end

  // APB answer: read data is captured in the setup cycle so the access ends with no wait.
  always_ff @(posedge pclk or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else if (clk_en) begin
      pready <= 1'b1; // R15
      pslverr <= 1'b0;
      if (psel && !penable && !pwrite) begin
        prdata <= rdata_nxt;
      end
    end
  end

endmodule : can_mode_ctrl

//--- test/can_bus_node.sv
// Other nodes on the bus, seen through a transceiver.
`timescale 1ns/1ps
module can_bus_node (
  input wire logic pclk, // Bench clock.
  input wire logic can_tx, // Block transmit pin.
  input wire logic talk, // High while another node sends.
  output logic can_rx // Wired-AND bus level.
);
  logic [1:0] ph_r; // Phase within the traffic pattern.
  // Traffic toggles every two clocks so that the bus never looks idle.
  always_ff @(posedge pclk) begin
    ph_r <= talk ? ph_r + 2'h1 : 2'h0;
  end
  // Dominant wins, so the bus is the AND of every driver.
  assign can_rx = can_tx & !(talk && ph_r[1]);
endmodule : can_bus_node

//--- test/can_mode_ctrl_bench.sv
// Self-checking bench for the mode, reset and interrupt block.
`timescale 1ns/1ps
module can_mode_ctrl_bench;
  import can_mode_pkg::*;
  logic pclk, presetn, clk_en, psel, penable, pwrite, pready, pslverr, talk;
  logic can_rx, can_tx, core_tx, core_rx, core_run, error_clear, bit_tick;
  logic tx_pending, tx_new_request, interrupt_out;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rdata;
  logic [15:0] err_count;
  core_event_s core_ev;
  mode_status_s mode_status;
  int fails = 0;
  int checked = 0;
  can_mode_ctrl uut (.pclk, .presetn, .clk_en, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .can_rx, .can_tx, .core_tx, .core_rx, .core_run, .error_clear,
    .bit_tick, .tx_pending, .tx_new_request, .err_count, .core_ev, .mode_status, .interrupt_out);
  can_bus_node node (.pclk, .can_tx, .talk, .can_rx);
  // Clock of 4 ns period.
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  task automatic stop_test();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : stop_test
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      $display("BAD %s expected %h seen %h", s, e, g);
      fails++;
    end
  endtask : chk
  // One APB transfer; the request is held until pready is seen high.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Only the watchdog ends a wait for the answer.
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rdata = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string s);
    apb(1'b0, a, 32'h0);
    chk(s, e, rdata);
  endtask : rd
  task automatic wait_mode(input logic [3:0] m);
    int n;
    n = 0;
    while (mode_status !== m && n < 400) begin
      @(posedge pclk);
      n++;
    end
    chk("mode", {28'h0, m}, {28'h0, mode_status});
    if (n >= 400) begin
      stop_test();
    end
  endtask : wait_mode
  // Outputs are looked at mid-cycle, where they have settled.
  task automatic look(input int n);
    repeat (n) @(posedge pclk);
    @(negedge pclk);
  endtask : look
  task automatic ev(input int b);
    @(posedge pclk);
    core_ev.irq_set[b] <= 1'b1;
    @(posedge pclk);
    core_ev <= 17'h0;
  endtask : ev
  task automatic t_reset();
    look(1);
    chk("can_tx", 32'h1, {31'h0, can_tx});
    chk("irq", 32'h0, {31'h0, interrupt_out});
    chk("pslverr", 32'h0, {31'h0, pslverr});
    rd(OFF_SR, 32'h1, "status");
    rd(OFF_ECR, 32'h0, "error count");
    rd(8'h2C, 32'h0, "unmapped");
    $display("reset test done");
  endtask : t_reset
  task automatic t_normal();
    wr(OFF_BAUD_PRESCALER_REG, 32'h5);
    rd(OFF_BAUD_PRESCALER_REG, 32'h5, "prescaler cfg");
    wr(OFF_BAUD_PRESCALER_REG, 32'h0);
    wr(OFF_SRR, 32'h2);
    rd(OFF_SR, 32'h1, "status wait");
    wait_mode(4'h8);
    @(posedge pclk);
    core_ev.esr_set <= 5'h06;
    @(posedge pclk);
    core_ev <= 17'h0;
    rd(OFF_ESR, 32'h6, "error status run");
    rd(OFF_ECR, 32'h1234, "error count run");
    wr(OFF_BAUD_PRESCALER_REG, 32'h7);
    rd(OFF_BAUD_PRESCALER_REG, 32'h0, "prescaler run");
    @(posedge pclk);
    core_tx <= 1'b0;
    look(2);
    chk("can_tx", 32'h0, {31'h0, can_tx});
    @(posedge pclk);
    core_tx <= 1'b1;
    $display("normal test done");
  endtask : t_normal
  task automatic t_irq();
    wr(OFF_IER, 32'h2);
    ev(IRQ_TX_DONE);
    look(2);
    chk("irq set", 32'h1, {31'h0, interrupt_out});
    wr(OFF_ICR, 32'h2);
    look(1);
    chk("irq clr", 32'h0, {31'h0, interrupt_out});
    rd(OFF_ISR, 32'h0, "flags clr");
    ev(IRQ_RX_DONE);
    look(2);
    chk("irq masked", 32'h0, {31'h0, interrupt_out});
    wr(OFF_IER, 32'h6);
    look(1);
    chk("irq enable", 32'h1, {31'h0, interrupt_out});
    ev(IRQ_TX_DONE);
    wr(OFF_ICR, 32'h2);
    look(0);
    chk("irq drop", 32'h0, {31'h0, interrupt_out});
    look(1);
    chk("irq again", 32'h1, {31'h0, interrupt_out});
    wr(OFF_IER, 32'h2);
    look(1);
    chk("irq disable", 32'h0, {31'h0, interrupt_out});
    wr(OFF_ICR, 32'h4);
    $display("interrupt test done");
  endtask : t_irq
  task automatic t_sleep();
    wr(OFF_MSR, 32'h2);
    wait_mode(4'h4);
    rd(OFF_ISR, 32'h40, "flags sleep");
    @(posedge pclk);
    tx_new_request <= 1'b1;
    @(posedge pclk);
    tx_new_request <= 1'b0;
    wait_mode(4'h8);
    rd(OFF_ISR, 32'hC0, "flags wake");
    wait_mode(4'h4);
    talk <= 1'b1;
    wait_mode(4'h8);
    talk <= 1'b0;
    wr(OFF_MSR, 32'h0);
    wait_mode(4'h8);
    wr(OFF_ICR, 32'hFF);
    $display("sleep test done");
  endtask : t_sleep
  task automatic t_cfg();
    ev(IRQ_ARB_LOST);
    ev(IRQ_RX_NOT_EMPTY);
    wr(OFF_SRR, 32'h0);
    wait_mode(4'h1);
    rd(OFF_ISR, 32'h100, "flags cfg");
    rd(OFF_ESR, 32'h0, "error status cfg");
    ev(IRQ_ARB_LOST);
    ev(IRQ_RX_UNDERFLOW);
    rd(OFF_ISR, 32'h300, "flags cfg set");
    wr(OFF_IER, 32'h200);
    look(1);
    chk("irq cfg", 32'h1, {31'h0, interrupt_out});
    wr(OFF_ICR, 32'hFFF);
    wr(OFF_IER, 32'h0);
    tx_pending <= 1'b1;
    wr(OFF_MSR, 32'h2);
    wr(OFF_SRR, 32'h2);
    look(80);
    chk("no sleep", 32'h0, {31'h0, mode_status.sleep});
    @(posedge pclk);
    tx_pending <= 1'b0;
    wait_mode(4'h4);
    wr(OFF_MSR, 32'h0);
    wait_mode(4'h8);
    $display("configuration test done");
  endtask : t_cfg
  task automatic t_loop();
    wr(OFF_SRR, 32'h0);
    wait_mode(4'h1);
    wr(OFF_MSR, 32'h1);
    wr(OFF_SRR, 32'h2);
    wait_mode(4'h2);
    @(posedge pclk);
    core_tx <= 1'b0;
    talk <= 1'b1;
    look(3);
    chk("loop tx", 32'h1, {31'h0, can_tx});
    chk("loop rx", 32'h0, {31'h0, core_rx});
    wr(OFF_MSR, 32'h0);
    look(60);
    wait_mode(4'h2);
    @(posedge pclk);
    core_tx <= 1'b1;
    talk <= 1'b0;
    $display("loop back test done");
  endtask : t_loop
  task automatic t_soft();
    wr(OFF_SRR, 32'h0);
    wr(OFF_AFMR, 32'h1234_5678);
    wr(OFF_BAUD_PRESCALER_REG, 32'h9);
    wr(OFF_IER, 32'h3);
    wr(OFF_SRR, 32'h1);
    wait_mode(4'h1);
    rd(OFF_SRR, 32'h0, "ctl self clear");
    rd(OFF_BAUD_PRESCALER_REG, 32'h0, "prescaler def");
    rd(OFF_IER, 32'h0, "enable def");
    rd(OFF_AFMR, 32'h1234_5678, "mask soft");
    wr(OFF_MSR, 32'h3);
    @(posedge pclk);
    presetn <= 1'b0;
    look(4);
    chk("mode rst", 32'h1, {28'h0, mode_status});
    @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
    rd(OFF_MSR, 32'h0, "mode sel def");
    rd(OFF_AFMR, 32'h1234_5678, "mask sys");
    $display("reset recovery test done");
  endtask : t_soft
  // Bounds the run should any wait hang.
  initial begin
    repeat (20000) @(posedge pclk);
    fails++;
    $display("BAD watchdog expected 0 seen 1");
    stop_test();
  end
  initial begin
    presetn = 1'b0;
    clk_en = 1'b1;
    {psel, penable, pwrite, talk, tx_pending, tx_new_request} = 6'h0;
    core_tx = 1'b1;
    paddr = 8'h00;
    pwdata = 32'h0;
    err_count = 16'h1234;
    core_ev = 17'h0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
    t_reset();
    t_normal();
    t_irq();
    t_sleep();
    t_cfg();
    t_loop();
    t_soft();
    stop_test();
  end
endmodule : can_mode_ctrl_bench
bind can_mode_ctrl can_mode_ctrl_properties props (.pclk, .presetn, .psel, .penable, .pready,
  .pwrite, .paddr, .pwdata, .can_rx, .can_tx, .core_run, .error_clear, .bit_tick, .tx_pending,
  .tx_new_request, .mode_status);

//--- test/can_mode_ctrl_properties.sv
// Concurrent checks on the ports of the mode, reset and interrupt block.
`timescale 1ns/1ps
module can_mode_ctrl_properties (
  input wire logic pclk, // Host clock.
  input wire logic presetn, // Reset, active low.
  input wire logic psel, // APB select.
  input wire logic penable, // APB access phase.
  input wire logic pready, // APB ready.
  input wire logic pwrite, // APB direction.
  input wire logic [7:0] paddr, // APB address.
  input wire logic [31:0] pwdata, // APB write data.
  input wire logic can_rx, // Bus level seen.
  input wire logic can_tx, // Bus level driven.
  input wire logic core_run, // Core may run.
  input wire logic error_clear, // Error counters held.
  input wire logic bit_tick, // Bit time pulse.
  input wire logic tx_pending, // Request queued.
  input wire logic tx_new_request, // New request pulse.
  input wire can_mode_pkg::mode_status_s mode_status // One-hot mode.
);
  import can_mode_pkg::*;
  logic [3:0] rec_r; // Bit times seen recessive in a row.
  logic ctl_wr; // Write to the reset/enable register taken.
  // Saturates so that a long idle bus never wraps back to a low count.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rec_r <= 4'h0;
    end else if (!can_rx || ctl_wr) begin
      rec_r <= 4'h0;
    end else if (bit_tick && rec_r != 4'hF) begin
      rec_r <= rec_r + 4'h1;
    end
  end
  // The write counts only at the edge where the slave takes it.
  assign ctl_wr = psel && penable && pready && pwrite && paddr == OFF_SRR;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_mode_one_hot: assert property ($onehot(mode_status))
    else $error("mode status not one-hot");
  a_cfg_quiet: assert property (mode_status.config_mode && $past(mode_status.config_mode)
    |-> can_tx && !core_run && error_clear) else $error("configuration not quiet");
  a_loop_tx_rec: assert property (mode_status.loop_back && $past(mode_status.loop_back)
    |-> can_tx) else $error("loop back drives dominant");
  a_soft_cfg: assert property (ctl_wr && pwdata[SRR_SOFT_RESET_BIT]
    |-> ##[1:2] mode_status.config_mode) else $error("soft reset without configuration");
  a_disable_cfg: assert property (ctl_wr && !pwdata[SRR_CORE_ENABLE_BIT]
    |-> ##[1:3] mode_status.config_mode) else $error("core disable without configuration");
  a_idle_exit: assert property ($fell(mode_status.config_mode) |-> rec_r >= 4'hA)
    else $error("configuration left before idle bus");
  a_sleep_clean: assert property ($rose(mode_status.sleep) |-> !$past(tx_pending))
    else $error("sleep entered with pending request");
  a_request_wake: assert property (mode_status.sleep && tx_new_request
    |-> ##[1:4] !mode_status.sleep) else $error("no wake on new request");
  a_loop_exit: assert property ($fell(mode_status.loop_back) |-> mode_status.config_mode)
    else $error("loop back left to other than configuration");
  a_normal_run: assert property (mode_status.normal && $past(mode_status.normal)
    |-> core_run) else $error("normal mode without core running");
endmodule : can_mode_ctrl_properties
